// ### common/timer16_pkg.sv
// Shared constants for the 16-bit timer core and its capture conditioner.
package timer16_pkg;
  // CPU byte addresses.
  localparam logic [3:0] ADDR_CNT_LO = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
  localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPB_HI = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI = 4'h7;
  localparam logic [3:0] ADDR_CTRL_A = 4'h8;
  localparam logic [3:0] ADDR_CTRL_B = 4'h9;
  localparam logic [3:0] ADDR_FLAGS = 4'ha;
  localparam logic [3:0] ADDR_MASK = 4'hb;
  // Field positions in the flag and mask registers.
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;
  localparam int FLAG_CAPTURE = 5;
  // Field positions in control_reg_a.
  localparam int CA_MODE_A = 6;
  localparam int CA_MODE_B = 4;
  localparam int CA_WAVE_LO = 0;
  // Field positions in control_reg_b.
  localparam int CB_FILTER = 7;
  localparam int CB_EDGE_RISE = 6;
  localparam int CB_USE_COMPARATOR = 5;
  localparam int CB_WAVE_HI = 3;
  localparam int CB_CLOCK_SELECT = 0;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Counter landmarks and fixed TOP values.
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  // Prescaler terminal counts for divide by 8, 64, 256 and 1024.
  localparam logic [9:0] PRESC_DIV8 = 10'h007;
  localparam logic [9:0] PRESC_DIV64 = 10'h03f;
  localparam logic [9:0] PRESC_DIV256 = 10'h0ff;
  localparam logic [9:0] PRESC_DIV1024 = 10'h3ff;
  // Equal samples needed by the capture noise filter.
  localparam int FILTER_SAMPLES = 4;
endpackage : timer16_pkg

// ### common/capture_if.sv
// Connection between the capture conditioner and the timer core.
`timescale 1ns/1ps
interface capture_if;
  logic noise_on;
  logic rising;
  logic use_comparator;
  logic event_pulse;
  modport conditioner (input noise_on, input rising, input use_comparator, output event_pulse);
  modport core (output noise_on, output rising, output use_comparator, input event_pulse);
endinterface : capture_if

// ### src/capture_filter.sv
// Synchroniser, noise filter and edge detector for the capture event.
`timescale 1ns/1ps
module capture_filter
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic capture_pin,
  input wire logic comparator_out,
  capture_if.conditioner cap
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [FILTER_SAMPLES-1:0] history;
    logic level;
    logic event_pulse;
  } filt_state_t;

  filt_state_t s_reg;
  filt_state_t s_next;

  always_comb
  begin
    logic cand;
    cand = 1'b0;
    s_next = s_reg;
    s_next.sync1 = cap.use_comparator ? comparator_out : capture_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.history = {s_reg.history[FILTER_SAMPLES-2:0], s_reg.sync2};
    if (!cap.noise_on)
    begin
      cand = s_reg.sync2;
    end
    else if (&s_reg.history)
    begin
      cand = 1'b1;
    end
    else if (~|s_reg.history)
    begin
      cand = 1'b0;
    end
    else
    begin
      cand = s_reg.level;
    end
    s_next.level = cand;
    s_next.event_pulse = (cand != s_reg.level) && (cand == cap.rising);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  assign cap.event_pulse = s_reg.event_pulse;
endmodule : capture_filter

// ### src/timer16_core.sv
// Sixteen-bit timer core with byte-wide CPU access through a shared high-byte holder.
`timescale 1ns/1ps
// How it works
// - Counter, compares and capture are 16 bits, reached as two CPU byte accesses.
// - One shared 8-bit holder carries the high half of every 16-bit write and of counter and capture reads.
// - Low-byte write loads held high byte and new low byte in one cycle; capture is loaded only when it is TOP.
// - Counter and capture low-byte reads copy the high byte into the holder; high read returns it.
// - Compare high-byte reads return the live high byte, not the holder.
// - Both control registers are accessed directly with no ordering constraint.
// - Four sources show in the flag register, each gated by a mask bit.
// - Tick from prescaler or external pin edge; no source leaves counter idle.
// - Buffered compares checked on every tick; match drives output and sets match flag.
// - Filtered pin or comparator edge copies the counter into capture register unless capture is TOP.
// - BOTTOM is 0x0000 and MAX is 0xFFFF.
// - TOP is 0x00FF, 0x01FF, 0x03FF, 0xFFFF, compare A or capture by mode.
// - Compare A as PWM TOP drives no PWM output and stays double buffered.
// - The timer runs only while the power gate bit is zero.
// - A CPU counter write beats any clear or count in the same cycle.
// - Clock select zero stops the timer; CPU access to the counter stays.
// - Capture flag sets with the copy; cleared by service or writing one.
module timer16_core
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic power_gate_bit,
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic external_tick_pin,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  output logic compare_output_a,
  output logic compare_output_b
);
  import timer16_pkg::*;

  typedef struct packed {
    logic [15:0] counter_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] active_a;
    logic [15:0] active_b;
    logic [15:0] capture_value;
    logic [7:0] hold_high;
    logic [7:0] control_reg_a;
    logic [7:0] control_reg_b;
    logic [7:0] irq_flag_reg;
    logic [7:0] irq_mask_reg;
    logic [9:0] presc;
    logic tick_sync1;
    logic tick_sync2;
    logic tick_prev;
    logic count_down;
    logic out_a;
    logic out_b;
    logic [7:0] rdata;
    logic [3:0] irq_req;
  } core_state_t;

  core_state_t s_reg;
  core_state_t s_next;

  capture_if cap ();

  capture_filter u_capture_filter (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .capture_pin(capture_pin),
    .comparator_out(comparator_out),
    .cap(cap)
  );

  function automatic logic is_pwm(input logic [3:0] wave);
    is_pwm = (wave[1:0] != 2'b00);
  endfunction : is_pwm

  function automatic logic is_phase(input logic [3:0] wave);
    is_phase = is_pwm(wave) && !wave[2];
  endfunction : is_phase

  function automatic logic top_is_cap(input logic [3:0] wave);
    top_is_cap = (wave == 4'hc) || (wave == 4'he) || (wave == 4'ha);
  endfunction : top_is_cap

  function automatic logic top_is_a(input logic [3:0] wave);
    top_is_a = (wave == 4'h4) || (wave == 4'hf) || (wave == 4'hb);
  endfunction : top_is_a

  function automatic logic [15:0] top_value(input logic [3:0] wave, input logic [15:0] cmp_a,
                                            input logic [15:0] cap_val);
    if (top_is_a(wave))
    begin
      top_value = cmp_a;
    end
    else if (top_is_cap(wave))
    begin
      top_value = cap_val;
    end
    else if (!is_pwm(wave))
    begin
      top_value = COUNT_MAX;
    end
    else if (wave[1:0] == 2'b01)
    begin
      top_value = TOP_8BIT;
    end
    else if (wave[1:0] == 2'b10)
    begin
      top_value = TOP_9BIT;
    end
    else
    begin
      top_value = TOP_10BIT;
    end
  endfunction : top_value

  // Next output pin level for one compare unit.
  function automatic logic wave_out(input logic cur, input logic [1:0] mode, input logic match,
                                    input logic bottom, input logic pwm, input logic phase,
                                    input logic down);
    wave_out = cur;
    if (mode == 2'b01)
    begin
      if (match)
      begin
        wave_out = !cur;
      end
    end
    else if (mode[1])
    begin
      if (match)
      begin
        wave_out = (phase && down) ? !mode[0] : mode[0];
      end
      else if (pwm && !phase && bottom)
      begin
        wave_out = !mode[0];
      end
    end
  endfunction : wave_out

  always_comb
  begin
    logic [3:0] wave;
    logic [2:0] csel;
    logic tick;
    logic running;
    logic [15:0] top;
    logic at_top;
    logic wrap;
    logic match_a;
    logic match_b;
    logic overflow;
    logic capture;
    logic [7:0] set_flags;
    logic [7:0] clr_flags;
    logic [1:0] mode_a;
    wave = 4'h0;
    csel = 3'h0;
    tick = 1'b0;
    running = 1'b0;
    top = COUNT_BOTTOM;
    at_top = 1'b0;
    wrap = 1'b0;
    match_a = 1'b0;
    match_b = 1'b0;
    overflow = 1'b0;
    capture = 1'b0;
    set_flags = 8'h00;
    clr_flags = 8'h00;
    mode_a = 2'b00;
    s_next = s_reg;
    wave = {s_reg.control_reg_b[CB_WAVE_HI +: 2], s_reg.control_reg_a[CA_WAVE_LO +: 2]};
    csel = s_reg.control_reg_b[CB_CLOCK_SELECT +: 3];
    running = !power_gate_bit && (csel != 3'h0);

    s_next.tick_sync1 = external_tick_pin;
    s_next.tick_sync2 = s_reg.tick_sync1;
    s_next.tick_prev = s_reg.tick_sync2;
    if (running)
    begin
      s_next.presc = s_reg.presc + 10'h001;
    end
    case (csel)
      3'h1: tick = 1'b1;
      3'h2: tick = (s_reg.presc[2:0] == PRESC_DIV8[2:0]);
      3'h3: tick = (s_reg.presc[5:0] == PRESC_DIV64[5:0]);
      3'h4: tick = (s_reg.presc[7:0] == PRESC_DIV256[7:0]);
      3'h5: tick = (s_reg.presc == PRESC_DIV1024);
      3'h6: tick = s_reg.tick_prev && !s_reg.tick_sync2;
      3'h7: tick = !s_reg.tick_prev && s_reg.tick_sync2;
      default: tick = 1'b0;
    endcase
    tick = tick && running;

    top = top_value(wave, s_reg.active_a, s_reg.capture_value);
    at_top = (s_reg.counter_value == top);
    match_a = tick && (s_reg.counter_value == s_reg.active_a);
    match_b = tick && (s_reg.counter_value == s_reg.active_b);
    if (tick)
    begin
      if (is_phase(wave))
      begin
        if (!s_reg.count_down && at_top)
        begin
          s_next.count_down = 1'b1;
          s_next.counter_value = s_reg.counter_value - 16'h0001;
          wrap = 1'b1;
        end
        else if (s_reg.count_down && (s_reg.counter_value == COUNT_BOTTOM))
        begin
          s_next.count_down = 1'b0;
          s_next.counter_value = s_reg.counter_value + 16'h0001;
          overflow = 1'b1;
        end
        else
        begin
          s_next.counter_value = s_reg.count_down ? s_reg.counter_value - 16'h0001
                                                  : s_reg.counter_value + 16'h0001;
        end
      end
      else
      begin
        s_next.count_down = 1'b0;
        if (at_top)
        begin
          s_next.counter_value = COUNT_BOTTOM;
          wrap = 1'b1;
        end
        else
        begin
          s_next.counter_value = s_reg.counter_value + 16'h0001;
        end
        overflow = is_pwm(wave) ? at_top : (s_reg.counter_value == COUNT_MAX);
      end
    end
    if (wrap && is_pwm(wave))
    begin
      s_next.active_a = s_reg.compare_value_a;
      s_next.active_b = s_reg.compare_value_b;
    end

    mode_a = s_reg.control_reg_a[CA_MODE_A +: 2];
    if (is_pwm(wave) && top_is_a(wave) && mode_a[1])
    begin
      mode_a = 2'b00;
    end
    s_next.out_a = wave_out(s_reg.out_a, mode_a, match_a, wrap, is_pwm(wave), is_phase(wave),
                            s_reg.count_down);
    s_next.out_b = wave_out(s_reg.out_b, s_reg.control_reg_a[CA_MODE_B +: 2], match_b, wrap,
                            is_pwm(wave), is_phase(wave), s_reg.count_down);

    capture = cap.event_pulse && !power_gate_bit && !top_is_cap(wave);
    if (capture)
    begin
      s_next.capture_value = s_reg.counter_value;
    end

    set_flags[FLAG_OVF] = overflow;
    set_flags[FLAG_MATCH_A] = match_a;
    set_flags[FLAG_MATCH_B] = match_b;
    set_flags[FLAG_CAPTURE] = capture;
    clr_flags[FLAG_OVF] = irq_ack[0];
    clr_flags[FLAG_MATCH_A] = irq_ack[1];
    clr_flags[FLAG_MATCH_B] = irq_ack[2];
    clr_flags[FLAG_CAPTURE] = irq_ack[3];

    // Writes come last so that they override counting.
    if (cpu_wr)
    begin
      if ((cpu_addr == ADDR_CNT_HI) || (cpu_addr == ADDR_CMPA_HI) || (cpu_addr == ADDR_CMPB_HI) ||
          (cpu_addr == ADDR_CAP_HI))
      begin
        s_next.hold_high = cpu_wdata;
      end
      else if (cpu_addr == ADDR_CNT_LO)
      begin
        s_next.counter_value = {s_reg.hold_high, cpu_wdata};
      end
      else if (cpu_addr == ADDR_CMPA_LO)
      begin
        s_next.compare_value_a = {s_reg.hold_high, cpu_wdata};
        if (!is_pwm(wave))
        begin
          s_next.active_a = {s_reg.hold_high, cpu_wdata};
        end
      end
      else if (cpu_addr == ADDR_CMPB_LO)
      begin
        s_next.compare_value_b = {s_reg.hold_high, cpu_wdata};
        if (!is_pwm(wave))
        begin
          s_next.active_b = {s_reg.hold_high, cpu_wdata};
        end
      end
      else if (cpu_addr == ADDR_CAP_LO)
      begin
        if (top_is_cap(wave))
        begin
          s_next.capture_value = {s_reg.hold_high, cpu_wdata};
        end
      end
      else if (cpu_addr == ADDR_CTRL_A)
      begin
        s_next.control_reg_a = cpu_wdata;
      end
      else if (cpu_addr == ADDR_CTRL_B)
      begin
        s_next.control_reg_b = cpu_wdata;
      end
      else if (cpu_addr == ADDR_FLAGS)
      begin
        clr_flags = clr_flags | cpu_wdata;
      end
      else if (cpu_addr == ADDR_MASK)
      begin
        s_next.irq_mask_reg = cpu_wdata;
      end
    end
    s_next.irq_flag_reg = (s_reg.irq_flag_reg & ~clr_flags) | set_flags;

    if (cpu_rd)
    begin
      if (cpu_addr == ADDR_CNT_LO)
      begin
        s_next.rdata = s_reg.counter_value[7:0];
        s_next.hold_high = s_reg.counter_value[15:8];
      end
      else if (cpu_addr == ADDR_CAP_LO)
      begin
        s_next.rdata = s_reg.capture_value[7:0];
        s_next.hold_high = s_reg.capture_value[15:8];
      end
      else if ((cpu_addr == ADDR_CNT_HI) || (cpu_addr == ADDR_CAP_HI))
      begin
        s_next.rdata = s_reg.hold_high;
      end
      else if (cpu_addr == ADDR_CMPA_LO)
      begin
        s_next.rdata = s_reg.compare_value_a[7:0];
      end
      else if (cpu_addr == ADDR_CMPA_HI)
      begin
        s_next.rdata = s_reg.compare_value_a[15:8];
      end
      else if (cpu_addr == ADDR_CMPB_LO)
      begin
        s_next.rdata = s_reg.compare_value_b[7:0];
      end
      else if (cpu_addr == ADDR_CMPB_HI)
      begin
        s_next.rdata = s_reg.compare_value_b[15:8];
      end
      else if (cpu_addr == ADDR_CTRL_A)
      begin
        s_next.rdata = s_reg.control_reg_a;
      end
      else if (cpu_addr == ADDR_CTRL_B)
      begin
        s_next.rdata = s_reg.control_reg_b;
      end
      else if (cpu_addr == ADDR_FLAGS)
      begin
        s_next.rdata = s_reg.irq_flag_reg;
      end
      else if (cpu_addr == ADDR_MASK)
      begin
        s_next.rdata = s_reg.irq_mask_reg;
      end
      else
      begin
        s_next.rdata = 8'h00;
      end
    end

    s_next.irq_req = {s_next.irq_flag_reg[FLAG_CAPTURE] & s_next.irq_mask_reg[FLAG_CAPTURE],
                      s_next.irq_flag_reg[FLAG_MATCH_B] & s_next.irq_mask_reg[FLAG_MATCH_B],
                      s_next.irq_flag_reg[FLAG_MATCH_A] & s_next.irq_mask_reg[FLAG_MATCH_A],
                      s_next.irq_flag_reg[FLAG_OVF] & s_next.irq_mask_reg[FLAG_OVF]};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else if (clk_en)
    begin
      s_reg <= s_next;
    end
  end

  assign cap.noise_on = s_reg.control_reg_b[CB_FILTER];
  assign cap.rising = s_reg.control_reg_b[CB_EDGE_RISE];
  assign cap.use_comparator = s_reg.control_reg_b[CB_USE_COMPARATOR];
  assign cpu_rdata = s_reg.rdata;
  assign irq_req = s_reg.irq_req;
  assign compare_output_a = s_reg.out_a;
  assign compare_output_b = s_reg.out_b;
endmodule : timer16_core

// ### testbench/timer16_core_chk.sv
// Port-level assertions for the sixteen-bit timer core.
`timescale 1ns/1ps
module timer16_core_chk
  import timer16_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic [3:0] irq_req,
  input wire logic compare_output_a,
  input wire logic compare_output_b
);
  logic [7:0] ctla_reg;
  logic [7:0] ctlb_reg;
  logic [7:0] mask_reg;
  logic [7:0] hold_reg;
  logic [15:0] cmpa_reg;
  logic [3:0] en_reg;
  logic [3:0] en_now;
  logic wr_ok;
  logic rd_ok;
  logic wave_zero;
  assign en_now = {mask_reg[FLAG_CAPTURE], mask_reg[FLAG_MATCH_B], mask_reg[FLAG_MATCH_A], mask_reg[FLAG_OVF]};
  assign wr_ok = clk_en && cpu_wr;
  assign rd_ok = clk_en && cpu_rd;
  assign wave_zero = ({ctlb_reg[CB_WAVE_HI +: 2], ctla_reg[CA_WAVE_LO +: 2]} == 4'h0);
  // Shadows of what the processor wrote.
  always_ff @(posedge clk)
  begin
    en_reg <= en_now;
    if (reset)
    begin
      ctla_reg <= CTRL_RESET;
      ctlb_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
      hold_reg <= 8'h00;
      cmpa_reg <= 16'h0000;
    end
    else if (wr_ok)
    begin
      if (cpu_addr == ADDR_CTRL_A) ctla_reg <= cpu_wdata;
      if (cpu_addr == ADDR_CTRL_B) ctlb_reg <= cpu_wdata;
      if (cpu_addr == ADDR_MASK) mask_reg <= cpu_wdata;
      if (cpu_addr[0] && cpu_addr < ADDR_CTRL_A) hold_reg <= cpu_wdata;
      if (cpu_addr == ADDR_CMPA_LO) cmpa_reg <= {hold_reg, cpu_wdata};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_unmapped_reads_zero: assert property (rd_ok && cpu_addr > ADDR_MASK |=> cpu_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_stands_idle: assert property (!rd_ok |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  a_ctrl_a_direct: assert property (rd_ok && cpu_addr == ADDR_CTRL_A |=> cpu_rdata == $past(ctla_reg))
    else $error("control a read mismatch");
  a_ctrl_b_direct: assert property (rd_ok && cpu_addr == ADDR_CTRL_B |=> cpu_rdata == $past(ctlb_reg))
    else $error("control b read mismatch");
  a_mask_reads_back: assert property (rd_ok && cpu_addr == ADDR_MASK |=> cpu_rdata == $past(mask_reg))
    else $error("mask read mismatch");
  a_cmpa_high_live: assert property (rd_ok && cpu_addr == ADDR_CMPA_HI && wave_zero
    |=> cpu_rdata == $past(cmpa_reg[15:8]))
    else $error("compare a high byte not live");
  a_cmpa_low_joined: assert property (rd_ok && cpu_addr == ADDR_CMPA_LO && wave_zero
    |=> cpu_rdata == $past(cmpa_reg[7:0]))
    else $error("compare a low byte mismatch");
  a_irq_needs_mask: assert property ((irq_req & ~en_now & ~en_reg) == 4'h0)
    else $error("request raised while masked");
  a_reset_quiet: assert property ($fell(reset) |-> irq_req == 4'h0 && !compare_output_a && !compare_output_b)
    else $error("outputs active after reset");
  cover property (irq_req[3]);
  cover property ($rose(compare_output_b));
  cover property (rd_ok && cpu_addr == ADDR_CNT_HI);
endmodule : timer16_core_chk
bind timer16_core timer16_core_chk chk_u (.clk(clk), .reset(reset), .clk_en(clk_en), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq_req(irq_req),
  .compare_output_a(compare_output_a), .compare_output_b(compare_output_b));

// ### testbench/cpu_model.sv
// Processor side model issuing byte accesses to the timer core.
`timescale 1ns/1ps
module cpu_model
(
  input wire logic clk,
  output logic [3:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial
  begin
    addr = 4'hf;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : put
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : get
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    put(a + 4'h1, v[15:8]);
    put(a, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    get(a, v[7:0]);
    get(a + 4'h1, v[15:8]);
  endtask : rd16
endmodule : cpu_model

// ### testbench/timer16_core_bench.sv
// Self-checking bench for the sixteen-bit timer core.
`timescale 1ns/1ps
module timer16_core_bench;
  import timer16_pkg::*;
  logic clk = 1'b0;
  logic reset, clk_en, power_gate_bit, ext_pin, cap_pin, cmp_out, cpu_wr, cpu_rd, out_a, out_b;
  logic [3:0] irq_ack, cpu_addr, irq_req;
  logic [7:0] cpu_wdata, cpu_rdata, b;
  logic [15:0] v;
  int err_total = 0;
  int total_checks = 0;
  logic [15:0] tops [4] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'h1234};
  logic [3:0] regs [5] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_FLAGS, ADDR_MASK, 4'hc};
  always #50 clk = ~clk;
  cpu_model cpu_u (.clk(clk), .addr(cpu_addr), .wr(cpu_wr), .rd(cpu_rd), .wdata(cpu_wdata), .rdata(cpu_rdata));
  timer16_core dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .power_gate_bit(power_gate_bit),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .external_tick_pin(ext_pin), .capture_pin(cap_pin), .comparator_out(cmp_out), .irq_ack(irq_ack),
    .irq_req(irq_req), .compare_output_a(out_a), .compare_output_b(out_b));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic wait_irq(input int n);
    int k;
    for (k = 0; k < 40 && irq_req[n] !== 1'b1; k++)
      @(posedge clk);
    if (k == 40)
    begin
      err_total++;
      $display("Error irq_req %0d expected 1 seen %b", n, irq_req[n]);
      print_verdict();
    end
  endtask : wait_irq
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    power_gate_bit = 1'b1;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    irq_ack = 4'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    foreach (regs[i])
    begin
      cpu_u.get(regs[i], b);
      check("reset byte", 16'(b), 16'h0000);
    end
    cpu_u.put(ADDR_CTRL_A, 8'hc0);
    cpu_u.get(ADDR_CTRL_A, b);
    check("control a", 16'(b), 16'h00c0);
    cpu_u.put(ADDR_CTRL_A, 8'h00);
    $display("test registers done");
    cpu_u.put(ADDR_CTRL_B, 8'h01);
    cpu_u.wr16(ADDR_CNT_LO, 16'h01ff);
    repeat (20) @(posedge clk);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("gated counter", v, 16'h01ff);
    cpu_u.put(ADDR_CMPA_HI, 8'hab);
    cpu_u.put(ADDR_CNT_LO, 8'h34);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("shared holder", v, 16'hab34);
    cpu_u.wr16(ADDR_CMPA_LO, 16'h1234);
    cpu_u.put(ADDR_CNT_HI, 8'h77);
    cpu_u.get(ADDR_CMPA_HI, b);
    check("compare a high", 16'(b), 16'h0012);
    cpu_u.get(ADDR_CMPA_LO, b);
    check("compare a low", 16'(b), 16'h0034);
    power_gate_bit <= 1'b0;
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    cpu_u.wr16(ADDR_CNT_LO, 16'h01ff);
    repeat (20) @(posedge clk);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("stopped counter", v, 16'h01ff);
    cpu_u.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_u.put(ADDR_CTRL_B, 8'h01);
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("frozen counter", v, 16'h0001);
    cpu_u.wr16(ADDR_CNT_LO, 16'h0100);
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("write beats count", v, 16'h0102);
    $display("test holder done");
    cpu_u.wr16(ADDR_CNT_LO, 16'hfff8);
    cpu_u.put(ADDR_CTRL_B, 8'h01);
    repeat (12) @(posedge clk);
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("wrapped at max", 16'(v < 16'h0010), 16'h0001);
    cpu_u.get(ADDR_FLAGS, b);
    check("overflow flag", 16'(b & 8'h01), 16'h0001);
    check("masked request", 16'(irq_req), 16'h0000);
    cpu_u.put(ADDR_MASK, 8'h01);
    repeat (3) @(posedge clk);
    check("unmasked request", 16'(irq_req), 16'h0001);
    irq_ack <= 4'h1;
    @(posedge clk);
    irq_ack <= 4'h0;
    repeat (2) @(posedge clk);
    check("serviced request", 16'(irq_req), 16'h0000);
    $display("test overflow done");
    cpu_u.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_u.put(ADDR_CTRL_B, 8'h07);
    repeat (5)
    begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("external ticks", v, 16'h0005);
    cpu_u.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_u.put(ADDR_CTRL_B, 8'h02);
    repeat (22) @(posedge clk);
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    cpu_u.rd16(ADDR_CNT_LO, v);
    check("prescaled ticks", v, 16'h0003);
    foreach (tops[i])
    begin
      cpu_u.put(ADDR_CTRL_A, (i == 3) ? 8'h00 : 8'(i + 1));
      cpu_u.wr16(ADDR_CNT_LO, tops[i] - 16'h0004);
      cpu_u.put(ADDR_CTRL_B, 8'h09);
      repeat (12) @(posedge clk);
      cpu_u.put(ADDR_CTRL_B, 8'h08);
      cpu_u.rd16(ADDR_CNT_LO, v);
      check("wrapped at top", 16'(v < 16'h0010), 16'h0001);
    end
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    $display("test top done");
    cpu_u.wr16(ADDR_CMPA_LO, 16'h0005);
    cpu_u.wr16(ADDR_CMPB_LO, 16'h0008);
    cpu_u.wr16(ADDR_CNT_LO, 16'h0000);
    cpu_u.put(ADDR_CTRL_A, 8'h50);
    cpu_u.put(ADDR_FLAGS, 8'h06);
    cpu_u.put(ADDR_MASK, 8'h04);
    cpu_u.put(ADDR_CTRL_B, 8'h01);
    wait_irq(2);
    cpu_u.put(ADDR_CTRL_B, 8'h00);
    check("output a toggled", 16'(out_a), 16'h0001);
    check("output b toggled", 16'(out_b), 16'h0001);
    cpu_u.put(ADDR_FLAGS, 8'h04);
    cpu_u.get(ADDR_FLAGS, b);
    check("match b cleared", 16'(b & 8'h04), 16'h0000);
    $display("test match done");
    cpu_u.wr16(ADDR_CNT_LO, 16'h4321);
    cpu_u.put(ADDR_CTRL_B, 8'h40);
    cpu_u.put(ADDR_MASK, 8'h20);
    cap_pin <= 1'b1;
    wait_irq(3);
    cpu_u.rd16(ADDR_CAP_LO, v);
    check("pin capture", v, 16'h4321);
    cpu_u.put(ADDR_FLAGS, 8'h20);
    cpu_u.get(ADDR_FLAGS, b);
    check("capture flag cleared", 16'(b & 8'h20), 16'h0000);
    cap_pin <= 1'b0;
    cpu_u.wr16(ADDR_CNT_LO, 16'h0abc);
    cpu_u.put(ADDR_CTRL_B, 8'he0);
    cmp_out <= 1'b1;
    repeat (2) @(posedge clk);
    cmp_out <= 1'b0;
    repeat (15) @(posedge clk);
    check("filtered spike", 16'(irq_req[3]), 16'h0000);
    cmp_out <= 1'b1;
    wait_irq(3);
    cpu_u.rd16(ADDR_CAP_LO, v);
    check("comparator capture", v, 16'h0abc);
    $display("test capture done");
    print_verdict();
  end
endmodule : timer16_core_bench
